// *** shared/fdc_defines.vh ***
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef FDC_DEFINES_VH
`define FDC_DEFINES_VH

// channel register indexes, byte address = {ch, index, 2'b00}
`define FDC_R_CTRL 3'h0
`define FDC_R_AMODE 3'h1
`define FDC_R_BLK 3'h2
`define FDC_R_REP 3'h3
`define FDC_R_SRC 3'h4
`define FDC_R_DST 3'h5
`define FDC_R_STAT 3'h6
// global registers
`define FDC_G_STAT 8'h80
`define FDC_G_MASK 8'h84
`define FDC_G_PRIO 8'h88

// control field positions
`define FDC_C_EN 0
`define FDC_C_SW 1
`define FDC_C_BS 2
`define FDC_C_TS 4
`define FDC_C_CRC 6
`define FDC_C_LINK 7

// address modes, reload points, trigger sources
`define FDC_AM_INC 2'h1
`define FDC_AM_DEC 2'h2
`define FDC_RL_BURST 2'h1
`define FDC_RL_BLOCK 2'h2
`define FDC_RL_TRANS 2'h3
`define FDC_TS_SW 2'h0
`define FDC_TS_PER 2'h1
`define FDC_TS_EVT 2'h2

// reset values
`define FDC_CTRL_RST 8'h00
`define FDC_AMODE_RST 8'h00
`define FDC_BLK_RST 16'h0001
`define FDC_REP_RST 8'h01
`define FDC_MASK_RST 8'h00

`endif

// *** hw/fdc_dma.v ***
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "fdc_defines.vh"

module fdc_dma #(
  parameter AW = 16
) (
  input wire CLK,
  input wire RST_B,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire [3:0] PERIPH_REQ,
  input wire [3:0] EVENT_REQ,
  output reg [AW-1:0] MEM_ADDR,
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  input wire MEM_ERR,
  output reg [7:0] CRC_DATA,
  output reg CRC_VALID,
  output wire IRQ
);

  localparam S_IDLE = 3'h0;
  localparam S_RD = 3'h1;
  localparam S_CAP = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_UPD = 3'h4;
  localparam [AW-1:0] ONE = 1;

  //------------------------------------------------------------
  // channel state
  //------------------------------------------------------------
  reg [7:0] ctrl [0:3];
  reg [7:0] amode [0:3];
  reg [15:0] blk [0:3];
  reg [7:0] rep [0:3];
  reg [AW-1:0] src0 [0:3];
  reg [AW-1:0] dst0 [0:3];
  reg [AW-1:0] sa [0:3];
  reg [AW-1:0] da [0:3];
  reg [16:0] bcnt [0:3];
  reg [8:0] rcnt [0:3];
  reg [3:0] pend;
  reg [7:0] stat;
  reg [7:0] mask;
  reg prio;
  reg [1:0] g;
  reg [1:0] last;
  reg [3:0] bleft;
  reg [2:0] st;
  reg [31:0] next_rdata;
  integer i;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // address step after each byte
  function [AW-1:0] step;
    input [AW-1:0] a;
    input [1:0] m;
    begin
      if (m == `FDC_AM_INC) begin
        step = a + ONE;
      end else if (m == `FDC_AM_DEC) begin
        step = a - ONE;
      end else begin
        step = a;
      end
    end
  endfunction

  // does the chosen reload point fall on this byte
  function rl_hit;
    input [1:0] rl;
    input bu;
    input bl;
    input tr;
    begin
      rl_hit = ((rl == `FDC_RL_BURST) & bu) | ((rl == `FDC_RL_BLOCK) & bl) |
               ((rl == `FDC_RL_TRANS) & tr);
    end
  endfunction

  // fixed order favours ch0; rotating starts after the last winner
  function [1:0] pick;
    input [3:0] r;
    input rr;
    input [1:0] lw;
    integer k;
    reg [1:0] c;
    reg f;
    begin
      pick = 2'h0;
      f = 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        c = rr ? (lw + 2'h1 + k[1:0]) : k[1:0];
        if (!f && r[c]) begin
          pick = c;
          f = 1'b1;
        end
      end
    end
  endfunction

  //------------------------------------------------------------
  // decode and triggers
  //------------------------------------------------------------
  wire glob = REG_ADDR[7];
  wire [1:0] wc = REG_ADDR[6:5];
  wire [2:0] idx = REG_ADDR[4:2];
  wire ch_wr = REG_WR & ~glob;
  wire [3:0] en;
  wire [3:0] hit;

  // each channel picks its own start source
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_trig
      wire [1:0] ts = ctrl[c][`FDC_C_TS+1:`FDC_C_TS];
      wire swp = ch_wr & ({30'h0, wc} == c) & (idx == `FDC_R_CTRL) & REG_WDATA[`FDC_C_SW];
      assign en[c] = ctrl[c][`FDC_C_EN];
      assign hit[c] = en[c] & (((ts == `FDC_TS_SW) & swp) |
                               ((ts == `FDC_TS_PER) & PERIPH_REQ[c]) |
                               ((ts == `FDC_TS_EVT) & EVENT_REQ[c]));
    end
  endgenerate

  //------------------------------------------------------------
  // per-byte bookkeeping of the granted channel
  //------------------------------------------------------------
  wire [3:0] req = pend & en;
  wire [1:0] pk = pick(req, prio, last);
  wire [7:0] am = amode[g];
  wire blk_end = (bcnt[g] == 17'h00001);
  wire bur_end = (bleft == 4'h1) | blk_end;
  wire tr_end = blk_end & (rcnt[g] == 9'h001);
  wire [AW-1:0] next_sa = rl_hit(am[3:2], bur_end, blk_end, tr_end) ? src0[g] :
                          step(sa[g], am[1:0]);
  wire [AW-1:0] next_da = rl_hit(am[7:6], bur_end, blk_end, tr_end) ? dst0[g] :
                          step(da[g], am[5:4]);
  wire grant = (st == S_IDLE) & (|req);
  wire [3:0] clr = grant ? (4'h1 << pk) : 4'h0;
  wire [3:0] done_ev = ((st == S_UPD) & tr_end) ? (4'h1 << g) : 4'h0;
  wire [3:0] err_ev = ((st == S_WR) & MEM_ERR) ? (4'h1 << g) : 4'h0;
  wire [7:0] w1c = (REG_WR && REG_ADDR == `FDC_G_STAT) ? REG_WDATA[7:0] : 8'h00;

  // level interrupt while any unmasked flag is pending
  assign IRQ = |(stat & mask);

  // load a channel's counters and working addresses for a new run
  task start_ch;
    input [1:0] n;
    begin
      bcnt[n] <= {blk[n] == 16'h0000, blk[n]};
      rcnt[n] <= {rep[n] == 8'h00, rep[n]};
      sa[n] <= src0[n];
      da[n] <= dst0[n];
    end
  endtask

  //------------------------------------------------------------
  // register file and transfer engine
  //------------------------------------------------------------
  // one process owns all channel state so software and engine
  // never fight; engine updates come last and win
  always @(posedge CLK) begin
    if (!RST_B) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctrl[i] <= `FDC_CTRL_RST;
        amode[i] <= `FDC_AMODE_RST;
        blk[i] <= `FDC_BLK_RST;
        rep[i] <= `FDC_REP_RST;
        src0[i] <= {AW{1'b0}};
        dst0[i] <= {AW{1'b0}};
        sa[i] <= {AW{1'b0}};
        da[i] <= {AW{1'b0}};
        bcnt[i] <= 17'h00000;
        rcnt[i] <= 9'h000;
      end
      pend <= 4'h0;
      stat <= 8'h00;
      mask <= `FDC_MASK_RST;
      prio <= 1'b0;
      g <= 2'h0;
      last <= 2'h3;
      bleft <= 4'h0;
      st <= S_IDLE;
      MEM_ADDR <= {AW{1'b0}};
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 8'h00;
      CRC_DATA <= 8'h00;
      CRC_VALID <= 1'b0;
    end else begin
      // new trigger beats a same-cycle grant clear
      pend <= (pend & ~clr) | hit;
      stat <= (stat & ~w1c) | {err_ev, done_ev};
      // software side
      if (REG_WR && glob) begin
        if (REG_ADDR == `FDC_G_MASK) begin
          mask <= REG_WDATA[7:0];
        end
        if (REG_ADDR == `FDC_G_PRIO) begin
          prio <= REG_WDATA[0];
        end
      end
      if (ch_wr) begin
        case (idx)
          `FDC_R_CTRL: begin
            // request bit is a strobe and is not stored
            ctrl[wc] <= REG_WDATA[7:0] & ~(8'h01 << `FDC_C_SW);
            if (REG_WDATA[`FDC_C_EN] && !en[wc]) begin
              start_ch(wc);
            end
          end
          `FDC_R_AMODE: amode[wc] <= REG_WDATA[7:0];
          `FDC_R_BLK: blk[wc] <= REG_WDATA[15:0];
          `FDC_R_REP: rep[wc] <= REG_WDATA[7:0];
          `FDC_R_SRC: begin
            src0[wc] <= REG_WDATA[AW-1:0];
            sa[wc] <= REG_WDATA[AW-1:0];
          end
          `FDC_R_DST: begin
            dst0[wc] <= REG_WDATA[AW-1:0];
            da[wc] <= REG_WDATA[AW-1:0];
          end
          default: begin
          end
        endcase
      end
      // engine: one byte takes read, wait, write, update
      case (st)
        S_IDLE: begin
          if (grant) begin
            g <= pk;
            last <= pk;
            bleft <= 4'h1 << ctrl[pk][`FDC_C_BS+1:`FDC_C_BS];
            st <= S_RD;
          end
        end
        S_RD: begin
          MEM_ADDR <= sa[g];
          MEM_RD <= 1'b1;
          st <= S_CAP;
        end
        S_CAP: begin
          MEM_RD <= 1'b0;
          st <= S_WR;
        end
        S_WR: begin
          if (MEM_ERR) begin
            // a failed read stops the channel, nothing is written
            ctrl[g][`FDC_C_EN] <= 1'b0;
            st <= S_IDLE;
          end else begin
            MEM_ADDR <= da[g];
            MEM_WR <= 1'b1;
            MEM_WDATA <= MEM_RDATA;
            CRC_DATA <= MEM_RDATA;
            CRC_VALID <= ctrl[g][`FDC_C_CRC];
            st <= S_UPD;
          end
        end
        S_UPD: begin
          MEM_WR <= 1'b0;
          CRC_VALID <= 1'b0;
          sa[g] <= next_sa;
          da[g] <= next_da;
          bleft <= bleft - 4'h1;
          if (blk_end) begin
            bcnt[g] <= {blk[g] == 16'h0000, blk[g]};
            rcnt[g] <= rcnt[g] - 9'h001;
          end else begin
            bcnt[g] <= bcnt[g] - 17'h00001;
          end
          if (tr_end) begin
            ctrl[g][`FDC_C_EN] <= 1'b0;
            if (ctrl[g][`FDC_C_LINK]) begin
              ctrl[g ^ 2'h1][`FDC_C_EN] <= 1'b1;
              start_ch(g ^ 2'h1);
            end
          end
          // a burst is never split: stay on this channel until it ends
          st <= bur_end ? S_IDLE : S_RD;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // read back
  //------------------------------------------------------------
  // working addresses and counters read live
  always @* begin
    next_rdata = 32'h00000000;
    if (glob) begin
      case (REG_ADDR)
        `FDC_G_STAT: next_rdata = {24'h000000, stat};
        `FDC_G_MASK: next_rdata = {24'h000000, mask};
        `FDC_G_PRIO: next_rdata = {31'h00000000, prio};
        default: next_rdata = 32'h00000000;
      endcase
    end else begin
      case (idx)
        `FDC_R_CTRL: next_rdata = {24'h000000, ctrl[wc]};
        `FDC_R_AMODE: next_rdata = {24'h000000, amode[wc]};
        `FDC_R_BLK: next_rdata = {16'h0000, blk[wc]};
        `FDC_R_REP: next_rdata = {24'h000000, rep[wc]};
        `FDC_R_SRC: next_rdata = {{(32-AW){1'b0}}, sa[wc]};
        `FDC_R_DST: next_rdata = {{(32-AW){1'b0}}, da[wc]};
        `FDC_R_STAT: next_rdata = {en[wc], 4'h0, pend[wc], rcnt[wc], bcnt[wc]};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always @(posedge CLK) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h00000000;
    end else begin
      REG_RDATA <= REG_RD ? next_rdata : 32'h00000000;
    end
  end

endmodule // fdc_dma

// *** bench/fdc_dma_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// memory and register port checks
// ----------------------------------------
module fdc_dma_properties #(
  parameter AW = 16
) (
  input wire CLK,
  input wire RST_B,
  input wire REG_RD,
  input wire [31:0] REG_RDATA,
  input wire [AW-1:0] MEM_ADDR,
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  input wire MEM_ERR,
  input wire [7:0] CRC_DATA,
  input wire CRC_VALID,
  input wire IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a read whose sample cycle came back clean or faulty
  sequence rd_ok; MEM_RD ##1 !MEM_ERR; endsequence
  sequence rd_bad; MEM_RD ##1 MEM_ERR; endsequence
  a_read_then_write: assert property (rd_ok |=> MEM_WR)
    else $error("write missing after clean read");
  a_wdata_matches: assert property (rd_ok |=> MEM_WDATA == $past(MEM_RDATA))
    else $error("written byte differs from read byte");
  a_error_blocks_write: assert property (rd_bad |=> !MEM_WR)
    else $error("write after faulty read");
  a_crc_with_write: assert property (CRC_VALID |-> MEM_WR && CRC_DATA == MEM_WDATA)
    else $error("checksum feed not tied to write");
  a_byte_spacing: assert property (MEM_RD |=> !MEM_RD [*3])
    else $error("reads closer than four cycles");
  a_write_after_read: assert property (MEM_WR |-> $past(MEM_RD, 2))
    else $error("write without read two cycles before");
  a_addr_holds: assert property ($changed(MEM_ADDR) |-> MEM_RD || MEM_WR)
    else $error("address moved between accesses");
  a_rdata_quiet: assert property (!REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data outside read answer cycle");
  a_reset_quiet: assert property ($rose(RST_B) |-> !MEM_RD && !MEM_WR && !IRQ)
    else $error("activity straight after reset");
endmodule // fdc_dma_properties
bind fdc_dma fdc_dma_properties #(.AW(AW)) fdc_dma_properties_i (.CLK(CLK), .RST_B(RST_B),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ERR(MEM_ERR),
  .CRC_DATA(CRC_DATA), .CRC_VALID(CRC_VALID), .IRQ(IRQ));

// *** bench/fdc_mem_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// memory and peripheral space model
// ----------------------------------------
module fdc_mem_model #(
  parameter logic [15:0] ERR_ADDR = 16'h0EEE
) (
  input wire clk,
  input wire [15:0] mem_addr,
  input wire mem_rd,
  output logic [7:0] mem_rdata = 8'h00,
  output logic mem_err = 1'b0
);
  // every address answers, so sram, registers and eeprom look alike; idle data toggles
  always @(posedge clk) begin
    if (mem_rd) begin
      mem_rdata <= mem_addr[7:0] ^ 8'h5A;
      mem_err <= (mem_addr == ERR_ADDR);
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_err <= 1'b0;
    end
  end
endmodule // fdc_mem_model

// *** bench/fdc_dma_tb.sv ***
`timescale 1ns/1ps
`include "fdc_defines.vh"
module fdc_dma_tb;
  typedef struct {logic [1:0] ch, bsel, ts; logic crc; logic [15:0] blk; logic [7:0] rep, am;
    logic [15:0] src, dst;} fdc_row_t;
  logic CLK, RST_B, REG_WR, REG_RD, MEM_RD, MEM_WR, MEM_ERR, CRC_VALID, IRQ;
  logic [7:0] REG_ADDR, MEM_WDATA, MEM_RDATA, CRC_DATA;
  logic [31:0] REG_WDATA, REG_RDATA, v;
  logic [3:0] PERIPH_REQ, EVENT_REQ;
  logic [15:0] MEM_ADDR, s, d;
  logic [15:0] rq[$], erq[$];
  logic [23:0] wq[$], ewq[$];
  int fails, total_checks, ncrc, bs, k, b, n;
  fdc_row_t rows[4] = '{'{0, 0, 0, 1, 3, 1, 8'h11, 16'h0100, 16'h0200},
    '{1, 1, 1, 0, 4, 2, 8'h29, 16'h0300, 16'h0400}, '{2, 2, 2, 0, 5, 1, 8'h50, 16'h0500, 16'h0600},
    '{3, 3, 0, 1, 8, 1, 8'h02, 16'h0700, 16'h0800}};
  fdc_row_t er = '{0, 0, 0, 0, 2, 1, 8'h00, 16'h0EEE, 16'h0200};
  fdc_row_t p0 = '{0, 0, 1, 0, 1, 1, 8'h00, 16'h0100, 16'h0200};
  fdc_row_t p2 = '{2, 0, 1, 0, 1, 1, 8'h00, 16'h0500, 16'h0600};
  fdc_row_t l1 = '{1, 0, 1, 0, 1, 1, 8'h00, 16'h0300, 16'h0400};
  fdc_dma #(.AW(16)) fdc_dma_i (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PERIPH_REQ(PERIPH_REQ), .EVENT_REQ(EVENT_REQ), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ERR(MEM_ERR),
    .CRC_DATA(CRC_DATA), .CRC_VALID(CRC_VALID), .IRQ(IRQ));
  fdc_mem_model fdc_mem_model_i (.clk(CLK), .mem_addr(MEM_ADDR), .mem_rd(MEM_RD),
    .mem_rdata(MEM_RDATA), .mem_err(MEM_ERR));
  // ----------------------------------------
  // bus tasks and helpers
  // ----------------------------------------
  function automatic [7:0] ra(input [1:0] ch, input [2:0] idx);
    ra = {1'b0, ch, idx, 2'b00};
  endfunction
  function automatic [31:0] cv(input fdc_row_t r);
    cv = {25'h0, r.crc, r.ts, r.bsel, 2'b01};
  endfunction
  function automatic [15:0] step(input [15:0] a, input [1:0] m);
    step = (m == `FDC_AM_INC) ? a + 16'h1 : (m == `FDC_AM_DEC) ? a - 16'h1 : a;
  endfunction
  function automatic bit rl(input [1:0] m, input int k, input int bs, input int blk);
    rl = (m == `FDC_RL_BURST && (k % bs == bs - 1 || k == blk - 1)) ||
      (m == `FDC_RL_BLOCK && k == blk - 1);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] dt);
    @(posedge CLK) {REG_ADDR, REG_WDATA, REG_WR} <= {a, dt, 1'b1};
    @(posedge CLK) REG_WR <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] dt);
    @(posedge CLK) {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge CLK) REG_RD <= 1'b0;
    @(negedge CLK) dt = REG_RDATA;
  endtask
  task cfg(input fdc_row_t r, input [31:0] c);
    rq.delete();
    wq.delete();
    ncrc = 0;
    wr(ra(r.ch, `FDC_R_AMODE), r.am);
    wr(ra(r.ch, `FDC_R_BLK), r.blk);
    wr(ra(r.ch, `FDC_R_REP), r.rep);
    wr(ra(r.ch, `FDC_R_SRC), r.src);
    wr(ra(r.ch, `FDC_R_DST), r.dst);
    wr(ra(r.ch, `FDC_R_CTRL), c);
  endtask
  // one trigger is one burst; 40 cycles cover an 8 byte burst at 4 cycles a byte
  task trig(input fdc_row_t r);
    if (r.ts == `FDC_TS_SW) wr(ra(r.ch, `FDC_R_CTRL), cv(r) | 32'h2);
    else begin
      @(posedge CLK) {EVENT_REQ, PERIPH_REQ} <= (r.ts == `FDC_TS_EVT) ? 8'h10 << r.ch : 8'h1 << r.ch;
      @(posedge CLK) {EVENT_REQ, PERIPH_REQ} <= 8'h00;
    end
    repeat (40) @(posedge CLK);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // samples settled outputs of the cycle that just ended
  always @(posedge CLK) begin
    if (MEM_RD === 1'b1) rq.push_back(MEM_ADDR);
    if (MEM_WR === 1'b1) wq.push_back({MEM_ADDR, MEM_WDATA});
    if (CRC_VALID === 1'b1) ncrc++;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    end_of_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {RST_B, REG_WR, REG_RD, REG_ADDR, REG_WDATA, PERIPH_REQ, EVENT_REQ} = '0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    rd(ra(0, `FDC_R_BLK), v); chk(v, `FDC_BLK_RST);
    rd(ra(3, `FDC_R_REP), v); chk(v, `FDC_REP_RST);
    rd(`FDC_G_MASK, v); chk(v, `FDC_MASK_RST);
    wr(8'h1C, 32'hFF); rd(8'h1C, v); chk(v, 32'h0);
    // each row: one channel, burst size, trigger and address mode
    foreach (rows[i]) begin
      cfg(rows[i], cv(rows[i]));
      bs = 1 << rows[i].bsel;
      repeat (rows[i].rep * ((rows[i].blk + bs - 1) / bs)) trig(rows[i]);
      {s, d} = {rows[i].src, rows[i].dst};
      erq.delete();
      ewq.delete();
      for (b = 0; b < rows[i].rep; b++) for (k = 0; k < rows[i].blk; k++) begin
        erq.push_back(s);
        ewq.push_back({d, s[7:0] ^ 8'h5A});
        {s, d} = {step(s, rows[i].am[1:0]), step(d, rows[i].am[5:4])};
        if (rl(rows[i].am[3:2], k, bs, rows[i].blk)) s = rows[i].src;
        if (rl(rows[i].am[7:6], k, bs, rows[i].blk)) d = rows[i].dst;
      end
      chk(wq.size(), ewq.size());
      foreach (ewq[j]) begin
        chk(rq[j], erq[j]);
        chk(wq[j], ewq[j]);
      end
      chk(ncrc, rows[i].crc ? ewq.size() : 0);
      rd(`FDC_G_STAT, v); chk(v, 32'h1 << rows[i].ch);
      rd(ra(rows[i].ch, `FDC_R_STAT), v); chk(v[31], 1'b0);
      wr(`FDC_G_MASK, 32'h1 << rows[i].ch); @(negedge CLK) chk(IRQ, 1'b1);
      wr(`FDC_G_STAT, 32'h1 << rows[i].ch); @(negedge CLK) chk(IRQ, 1'b0);
    end
    // finished channels ignore further triggers
    n = wq.size();
    @(posedge CLK) {EVENT_REQ, PERIPH_REQ} <= 8'hFF;
    @(posedge CLK) {EVENT_REQ, PERIPH_REQ} <= 8'h00;
    repeat (40) @(posedge CLK);
    chk(wq.size(), n);
    // faulty read aborts the burst and flags the channel
    cfg(er, cv(er));
    trig(er);
    chk(rq.size(), 1);
    chk(wq.size(), 0);
    rd(`FDC_G_STAT, v); chk(v, 32'h10);
    wr(`FDC_G_MASK, 32'h10); @(negedge CLK) chk(IRQ, 1'b1);
    wr(`FDC_G_STAT, 32'h10);
    // two channels triggered together, fixed order serves channel 0 first
    cfg(p2, cv(p2));
    cfg(p0, cv(p0));
    @(posedge CLK) PERIPH_REQ <= 4'h5;
    @(posedge CLK) PERIPH_REQ <= 4'h0;
    repeat (40) @(posedge CLK);
    chk({rq[0], rq[1]}, {16'h0100, 16'h0500});
    // rotating order: once channel 0 has won, channel 2 goes first
    wr(`FDC_G_PRIO, 32'h1);
    cfg(p0, cv(p0));
    trig(p0);
    cfg(p2, cv(p2));
    cfg(p0, cv(p0));
    @(posedge CLK) PERIPH_REQ <= 4'h5;
    @(posedge CLK) PERIPH_REQ <= 4'h0;
    repeat (40) @(posedge CLK);
    chk({rq[0], rq[1]}, {16'h0500, 16'h0100});
    // linked pair: channel 0 done enables channel 1
    cfg(l1, cv(l1) & 32'hFE);
    cfg(p0, cv(p0) | 32'h80);
    trig(p0);
    rd(ra(1, `FDC_R_STAT), v); chk(v[31], 1'b1);
    trig(l1);
    chk(wq[wq.size() - 1], {l1.dst, l1.src[7:0] ^ 8'h5A});
    end_of_test;
  end
endmodule // fdc_dma_tb
